// File: logic/dual_timer_counter_unit.sv
// two 16-bit timer/counters with mode, control and power control registers
//
// Overview of operation
// - two independent 16-bit timer/counters, each split into low and high bytes
// - timing mode advances the count once per machine cycle of 12 clocks
// - counting mode advances the count on each falling edge of the count input
// - edge recognition takes two machine cycles, limiting input rate to one 24th of the clock
// - run bit 6 starts unit one, run bit 4 starts unit zero
// - mode 00 is 13-bit with low byte top three bits zero; mode 01 is 16-bit
// - mode 10 counts low byte and reloads it from high byte on overflow
// - unit one in mode 11 stops counting
// - unit zero in mode 11 runs low and high bytes as two 8-bit counters
// - in split mode low byte follows run zero and gate, sets flag zero
// - in split mode high byte follows run one and sets flag one
// - stop bit halts both units until an external interrupt arrives
// - idle bit holds program fetch until an internal interrupt such as overflow
// - with gate clear, counter/timer select 1 counts external edges, 0 counts machine cycles
// - gate set counts falling edges of the gate source while run is set
// - overflow sets the flag; software or interrupt service clears it
// - mode of unit one sits in bits 5:4, unit zero in bits 1:0
`include "timer_map.svh"

module dual_timer_counter_unit (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // external count and gate sources
  input  wire logic       count_input_zero,
  input  wire logic       count_input_one,
  input  wire logic       gate_source_zero,
  input  wire logic       gate_source_one,
  // interrupt side
  input  wire logic       ext_int_wake,
  input  wire logic       int_ack_zero,
  input  wire logic       int_ack_one,
  output logic            overflow_flag_zero,
  output logic            overflow_flag_one,
  // power control
  output logic            program_fetch_hold,
  output logic            peripheral_stop
);

  // register state
  logic [7:0] timer_mode_register_q, timer_mode_register_d;
  logic       run0_q, run0_d, run1_q, run1_d;
  logic       ovf0_q, ovf0_d, ovf1_q, ovf1_d;
  logic       baud_q, baud_d, stop_q, stop_d, idle_q, idle_d;
  logic [7:0] tl0_q, tl0_d, th0_q, th0_d, tl1_q, tl1_d, th1_q, th1_d;
  logic [7:0] rdata_q, rdata_d;
  logic [3:0] div_q, div_d;

  // decoded controls
  timer_pkg::mode_t mode0, mode1;
  logic       gate0, gate1, ct0, ct1;
  logic       mc_en;
  logic [3:0] fall;
  logic       tick0, tick1, tick_hi0;
  logic       wr_cnt;
  logic       set0, set1;
  logic [15:0] cnt0, cnt1;
  logic       trim0, trim1;

  assign mode0 = timer_pkg::mode_t'(timer_mode_register_q[`TIMER_MODE_REGISTER_MODE_ZERO_LSB +: 2]);
  assign mode1 = timer_pkg::mode_t'(timer_mode_register_q[`TIMER_MODE_REGISTER_MODE_ONE_LSB +: 2]);
  assign gate0 = timer_mode_register_q[`TIMER_MODE_REGISTER_GATE_ZERO];
  assign gate1 = timer_mode_register_q[`TIMER_MODE_REGISTER_GATE_ONE];
  assign ct0   = timer_mode_register_q[`TIMER_MODE_REGISTER_CT_ZERO];
  assign ct1   = timer_mode_register_q[`TIMER_MODE_REGISTER_CT_ONE];
  assign cnt0  = {th0_q, tl0_q};
  assign cnt1  = {th1_q, tl1_q};

  // entering 13-bit mode clears stale top bits, which moves a count without a step
  assign trim0 = (mode0 == timer_pkg::mode_13bit) && (tl0_q[7:5] != 3'h0);
  assign trim1 = (mode1 == timer_pkg::mode_13bit) && (tl1_q[7:5] != 3'h0);

  // one step of a unit: returns {overflow, high, low}
  function automatic logic [16:0] advance(input timer_pkg::mode_t m, input logic [15:0] v);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    s13 = {1'b0, v[15:8], v[4:0]} + 14'h1;
    s16 = {1'b0, v} + 17'h1;
    s8  = {1'b0, v[7:0]} + 9'h1;
    case (m)
      timer_pkg::mode_13bit:  advance = {s13[13], s13[12:5], 3'h0, s13[4:0]};
      timer_pkg::mode_16bit:  advance = s16;
      timer_pkg::mode_reload: advance = {s8[8], v[15:8], s8[8] ? v[15:8] : s8[7:0]};
      default:                advance = {s8[8], v[15:8], s8[7:0]};
    endcase
  endfunction : advance

  // input sampling: count inputs on bits 1:0, gate sources on bits 3:2
  edge_sampler #(
    .WIDTH (4)
  ) u_edges (
    .clk        (clk),
    .rst        (rst),
    .sample_en  (mc_en),
    .pin_in     ({gate_source_one, gate_source_zero, count_input_one, count_input_zero}),
    .fall_pulse (fall)
  );

  // machine cycle divider, frozen while stopped
  always_comb begin
    div_d = div_q;
    if (!stop_q) begin
      div_d = (div_q == 4'(`MACHINE_CYCLE_CLKS - 1)) ? 4'h0 : div_q + 4'h1;
    end
  end
  assign mc_en = !stop_q && (div_q == 4'(`MACHINE_CYCLE_CLKS - 1));

  // step sources per unit
  always_comb begin
    tick0 = run0_q && (gate0 ? fall[2] : (ct0 ? fall[0] : mc_en));
    tick1 = run1_q && (mode1 != timer_pkg::mode_split)
         && (gate1 ? fall[3] : (ct1 ? fall[1] : mc_en));
    tick_hi0 = (mode0 == timer_pkg::mode_split) && run1_q && mc_en;
  end

  assign wr_cnt = sfr_wr && (sfr_addr >= `ADDR_COUNT_LOW_ZERO) && (sfr_addr <= `ADDR_COUNT_HIGH_ONE);

  // counting, overflow flags and register writes
  always_comb begin
    logic [16:0] n0;
    logic [16:0] n1;
    logic [8:0]  h0;
    n0 = advance(mode0, cnt0);
    n1 = advance(mode1, cnt1);
    h0 = {1'b0, th0_q} + 9'h1;
    tl0_d = tl0_q;
    th0_d = th0_q;
    tl1_d = tl1_q;
    th1_d = th1_q;
    set0 = 1'b0;
    set1 = 1'b0;
    if (tick0) begin
      tl0_d = n0[7:0];
      set0  = n0[16];
      if (mode0 != timer_pkg::mode_split) begin
        th0_d = n0[15:8];
      end
    end
    if (tick_hi0) begin
      th0_d = h0[7:0];
      set1  = h0[8];
    end
    if (tick1) begin
      {th1_d, tl1_d} = n1[15:0];
      // in split mode flag one belongs to the high byte of unit zero
      if (mode0 != timer_pkg::mode_split) begin
        set1 = n1[16];
      end
    end
    // software write overrides a step in the same cycle
    if (sfr_wr) begin
      case (sfr_addr)
        `ADDR_COUNT_LOW_ZERO:  tl0_d = sfr_wdata;
        `ADDR_COUNT_LOW_ONE:   tl1_d = sfr_wdata;
        `ADDR_COUNT_HIGH_ZERO: th0_d = sfr_wdata;
        `ADDR_COUNT_HIGH_ONE:  th1_d = sfr_wdata;
        default: ;
      endcase
    end
    // 13-bit mode keeps the unused low byte bits at zero
    if (mode0 == timer_pkg::mode_13bit) begin
      tl0_d[7:5] = 3'h0;
    end
    if (mode1 == timer_pkg::mode_13bit) begin
      tl1_d[7:5] = 3'h0;
    end
  end

  // control, mode and power registers
  always_comb begin
    timer_mode_register_d = timer_mode_register_q;
    run0_d = run0_q;
    run1_d = run1_q;
    ovf0_d = ovf0_q && !int_ack_zero;
    ovf1_d = ovf1_q && !int_ack_one;
    baud_d = baud_q;
    stop_d = stop_q;
    idle_d = idle_q;
    if (sfr_wr) begin
      case (sfr_addr)
        `ADDR_TIMER_MODE: timer_mode_register_d = sfr_wdata;
        `ADDR_TIMER_CONTROL: begin
          run1_d = sfr_wdata[`TIMER_CONTROL_REGISTER_RUN_ONE];
          run0_d = sfr_wdata[`TIMER_CONTROL_REGISTER_RUN_ZERO];
          ovf1_d = ovf1_d && sfr_wdata[`TIMER_CONTROL_REGISTER_OVF_ONE];
          ovf0_d = ovf0_d && sfr_wdata[`TIMER_CONTROL_REGISTER_OVF_ZERO];
        end
        `ADDR_POWER_CONTROL: begin
          baud_d = sfr_wdata[`POWER_CONTROL_BAUD_DOUBLE];
          stop_d = sfr_wdata[`POWER_CONTROL_STOP];
          idle_d = sfr_wdata[`POWER_CONTROL_IDLE];
        end
        default: ;
      endcase
    end
    // a hardware set wins over any clear in the same cycle
    ovf0_d = ovf0_d || set0;
    ovf1_d = ovf1_d || set1;
    if (ext_int_wake) begin
      stop_d = 1'b0;
    end
    if (set0 || set1) begin
      idle_d = 1'b0;
    end
  end

  // registered read data, unmapped addresses read zero
  always_comb begin
    rdata_d = rdata_q;
    if (sfr_rd) begin
      case (sfr_addr)
        `ADDR_POWER_CONTROL:   rdata_d = {baud_q, 5'h00, stop_q, idle_q};
        `ADDR_TIMER_CONTROL:   rdata_d = {ovf1_q, run1_q, ovf0_q, run0_q, 4'h0};
        `ADDR_TIMER_MODE:      rdata_d = timer_mode_register_q;
        `ADDR_COUNT_LOW_ZERO:  rdata_d = tl0_q;
        `ADDR_COUNT_LOW_ONE:   rdata_d = tl1_q;
        `ADDR_COUNT_HIGH_ZERO: rdata_d = th0_q;
        `ADDR_COUNT_HIGH_ONE:  rdata_d = th1_q;
        default:               rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_mode_register_q  <= `RESET_BYTE;
      run0_q  <= 1'b0;
      run1_q  <= 1'b0;
      ovf0_q  <= 1'b0;
      ovf1_q  <= 1'b0;
      baud_q  <= 1'b0;
      stop_q  <= 1'b0;
      idle_q  <= 1'b0;
      tl0_q   <= `RESET_BYTE;
      th0_q   <= `RESET_BYTE;
      tl1_q   <= `RESET_BYTE;
      th1_q   <= `RESET_BYTE;
      rdata_q <= `RESET_BYTE;
      div_q   <= 4'h0;
    end else begin
      timer_mode_register_q  <= timer_mode_register_d;
      run0_q  <= run0_d;
      run1_q  <= run1_d;
      ovf0_q  <= ovf0_d;
      ovf1_q  <= ovf1_d;
      baud_q  <= baud_d;
      stop_q  <= stop_d;
      idle_q  <= idle_d;
      tl0_q   <= tl0_d;
      th0_q   <= th0_d;
      tl1_q   <= tl1_d;
      th1_q   <= th1_d;
      rdata_q <= rdata_d;
      div_q   <= div_d;
    end
  end

  assign sfr_rdata          = rdata_q;
  assign overflow_flag_zero = ovf0_q;
  assign overflow_flag_one  = ovf1_q;
  assign program_fetch_hold = idle_q || stop_q;
  assign peripheral_stop    = stop_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_machine_cycle_gap: assert property (mc_en |=> !mc_en [*8])
    else $error("machine cycle strobe repeated too early");
  a_machine_cycle_period: assert property ((mc_en ##1 !stop_q [*8] ##1 !stop_q [*4]) |-> mc_en)
    else $error("machine cycle strobe missing after twelve clocks");
  a_timer_step_one: assert property ((mc_en && run0_q && !gate0 && !ct0 && mode0 == timer_pkg::mode_16bit
      && !wr_cnt) |=> cnt0 == $past(cnt0) + 16'h1)
    else $error("timer zero did not advance on a machine cycle");
  a_edge_only_count: assert property ((ct1 && !gate1 && !fall[1] && !wr_cnt && !trim1) |=> $stable(cnt1))
    else $error("counter one moved without an input edge");
  a_stop_freezes: assert property ((stop_q && !wr_cnt && !trim0 && !trim1) |=> $stable(cnt0) && $stable(cnt1))
    else $error("count changed while stopped");
  a_run_one_off: assert property ((!run1_q && !wr_cnt && !trim1) |=> $stable(cnt1))
    else $error("unit one counted with run bit clear");
  a_split_halts_one: assert property ((mode1 == timer_pkg::mode_split && !wr_cnt) |=> $stable(cnt1))
    else $error("unit one counted in mode 11");
  a_low_bits_zero: assert property ((mode0 == timer_pkg::mode_13bit && $past(mode0) == timer_pkg::mode_13bit)
      |-> tl0_q[7:5] == 3'h0)
    else $error("13-bit low byte top bits not zero");
  a_reload_copy: assert property ((tick1 && mode1 == timer_pkg::mode_reload && tl1_q == 8'hFF && !wr_cnt
      && mode0 != timer_pkg::mode_split) |=> tl1_q == $past(th1_q) && ovf1_q)
    else $error("reload did not copy high byte");
  a_split_high_flag: assert property ((tick_hi0 && th0_q == 8'hFF && !wr_cnt) |=> th0_q == 8'h00 && ovf1_q)
    else $error("split high byte overflow did not set flag one");
  a_wrap_sixteen: assert property ((tick0 && mode0 == timer_pkg::mode_16bit && cnt0 == 16'hFFFF && !wr_cnt)
      |=> cnt0 == 16'h0000 && ovf0_q)
    else $error("16-bit wrap or flag wrong");
  a_set_beats_ack: assert property (set0 |=> ovf0_q)
    else $error("overflow lost against a clear");
  a_wake_clears_stop: assert property ((stop_q && ext_int_wake) |=> !stop_q)
    else $error("external interrupt did not end stop");

  c_reload_overflow: cover property (tick1 && mode1 == timer_pkg::mode_reload && tl1_q == 8'hFF);
  c_split_both: cover property (tick0 && tick_hi0 && mode0 == timer_pkg::mode_split);
  c_edge_count: cover property (tick1 && ct1);
  c_stop_wake: cover property (stop_q ##1 !stop_q);

endmodule : dual_timer_counter_unit

// File: logic/timer_map.svh
// register addresses, field positions and timing counts of the dual timer/counter unit
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

`define ADDR_POWER_CONTROL    8'h87
`define ADDR_TIMER_CONTROL    8'h88
`define ADDR_TIMER_MODE       8'h89
`define ADDR_COUNT_LOW_ZERO   8'h8A
`define ADDR_COUNT_LOW_ONE    8'h8B
`define ADDR_COUNT_HIGH_ZERO  8'h8C
`define ADDR_COUNT_HIGH_ONE   8'h8D

`define TIMER_CONTROL_REGISTER_OVF_ONE          7
`define TIMER_CONTROL_REGISTER_RUN_ONE          6
`define TIMER_CONTROL_REGISTER_OVF_ZERO         5
`define TIMER_CONTROL_REGISTER_RUN_ZERO         4

`define TIMER_MODE_REGISTER_GATE_ONE         7
`define TIMER_MODE_REGISTER_CT_ONE           6
`define TIMER_MODE_REGISTER_MODE_ONE_LSB     4
`define TIMER_MODE_REGISTER_GATE_ZERO        3
`define TIMER_MODE_REGISTER_CT_ZERO          2
`define TIMER_MODE_REGISTER_MODE_ZERO_LSB    0

`define POWER_CONTROL_BAUD_DOUBLE      7
`define POWER_CONTROL_STOP             1
`define POWER_CONTROL_IDLE             0

`define RESET_BYTE            8'h00
`define CLK_PERIOD_NS         10
`define MACHINE_CYCLE_CLKS    12

`endif

// File: logic/timer_pkg.sv
// types shared by the dual timer/counter unit
package timer_pkg;

  // mode select field encodings
  typedef enum logic [1:0] {
    mode_13bit  = 2'h0,
    mode_16bit  = 2'h1,
    mode_reload = 2'h2,
    mode_split  = 2'h3
  } mode_t;

endpackage : timer_pkg

// File: logic/edge_sampler.sv
// synchronises external inputs and flags falling edges seen across machine cycles
module edge_sampler #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // machine cycle strobe
  input  wire logic             sample_en,
  // asynchronous pins and edge pulses
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] fall_pulse
);

  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] sync2_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] level_d;

  // level is sampled once per machine cycle, so an edge needs two of them
  always_comb begin
    level_d = sample_en ? sync2_q : level_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= '1;
      sync2_q <= '1;
      level_q <= '1;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      level_q <= level_d;
    end
  end

  // high at previous sample, low now
  assign fall_pulse = {WIDTH{sample_en}} & level_q & ~sync2_q;

endmodule : edge_sampler

// File: dv/count_source.sv
// behavioural source of falling edges for a count or gate input
module count_source #(
  parameter int HOLD = 14
) (
  // clock
  input  wire logic       clk,
  // request: number of falling edges to make
  input  wire logic       start,
  input  wire logic [7:0] n,
  // driven line and activity flag
  output logic            line,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;

  // each level held longer than a machine cycle so every edge is seen
  initial begin
    line = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (start) begin
        busy <= 1'b1;
        repeat (n) begin
          repeat (HOLD) @(posedge clk);
          line <= 1'b0;
          repeat (HOLD) @(posedge clk);
          line <= 1'b1;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : count_source

// File: dv/test_dual_timer_counter_unit.sv
// self-checking bench for the dual timer/counter unit
module test_dual_timer_counter_unit;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk = 0, rst = 1, wr_q = 0, rd_q = 0, wake = 0, ack0 = 0, ack1 = 0, st0 = 0, stg = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, r, nz = 8'h00;
  logic       cin0, gsrc0, ovf0, ovf1, hold, stop, b0, bg;
  int         n_fail = 0, comparisons = 0, cyc = 0, seed = 10;

  always #5 clk = ~clk;

  dual_timer_counter_unit dual_timer_counter_unit_inst (
    .clk(clk), .rst(rst), .sfr_addr(addr), .sfr_wr(wr_q), .sfr_rd(rd_q), .sfr_wdata(wdata),
    .sfr_rdata(rdata), .count_input_zero(cin0), .count_input_one(cin0), .gate_source_zero(gsrc0),
    .gate_source_one(gsrc0), .ext_int_wake(wake), .int_ack_zero(ack0), .int_ack_one(ack1),
    .overflow_flag_zero(ovf0), .overflow_flag_one(ovf1), .program_fetch_hold(hold),
    .peripheral_stop(stop));
  count_source count_source_inst (.clk(clk), .start(st0), .n(nz), .line(cin0), .busy(b0));
  count_source gate_src_inst (.clk(clk), .start(stg), .n(nz), .line(gsrc0), .busy(bg));

  task automatic test_done;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // hang guard sized well beyond the longest reload wait
  always @(posedge clk) begin
    cyc++;
    if (cyc > 30000) begin
      n_fail++;
      $display("BAD %0t timeout", $time);
      test_done;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_in(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    comparisons++;
    if (!(got >= lo && got <= hi)) begin
      n_fail++;
      $display("BAD %0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask : chk_in

  function automatic logic [7:0] low13(input logic [7:0] d);
    return d & 8'h1F; // top three bits of the low byte stay clear
  endfunction : low13

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_q <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr_q <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_q <= 1'b1; addr <= a;
    @(posedge clk);
    rd_q <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic wait_flag(input int one, input int lim);
    int k;
    k = 0;
    while ((one ? ovf1 : ovf0) !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    #1;
  endtask : wait_flag

  // start a partner burst and wait for it to finish, bounded
  task automatic burst(input int gate);
    int k;
    k = 0;
    @(posedge clk);
    if (gate) stg <= 1'b1; else st0 <= 1'b1;
    @(posedge clk);
    stg <= 1'b0; st0 <= 1'b0;
    repeat (2) @(posedge clk);
    while ((b0 || bg) && k < 3000) begin
      @(posedge clk);
      k++;
    end
    repeat (40) @(posedge clk);
  endtask : burst

  initial begin
    r = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int a = 8'h87; a <= 8'h8E; a++) begin
      rd(a[7:0], v); chk(v, 8'h00);
    end
    wr(8'h87, 8'hFC); rd(8'h87, v); chk(v, 8'h80);
    $display("test reset and map done");
    for (int i = 0; i < 4; i++) begin
      r = 8'($random(seed));
      wr(8'h89, 8'h00); wr(8'h8A, r); rd(8'h8A, v); chk(v, low13(r));
      wr(8'h89, 8'h01); wr(8'h8D, r); rd(8'h8D, v); chk(v, r);
    end
    $display("test byte access done");
    wr(8'h8A, 8'h00); wr(8'h8C, 8'h00); wr(8'h88, 8'h10);
    repeat (120) @(posedge clk);
    wr(8'h88, 8'h00); rd(8'h8A, v); chk_in(v, 8'h09, 8'h0B);
    wr(8'h8A, 8'hFF); wr(8'h8C, 8'hFF); wr(8'h88, 8'h10);
    wait_flag(0, 30); chk({7'h00, ovf0}, 8'h01);
    rd(8'h8A, v); chk_in(v, 8'h00, 8'h01); rd(8'h8C, v); chk(v, 8'h00);
    @(posedge clk) ack0 <= 1'b1;
    @(posedge clk) ack0 <= 1'b0;
    #1 chk({7'h00, ovf0}, 8'h00);
    $display("test timing and wrap done");
    r = 8'($unsigned($random(seed)) % 240); // keeps r + 1 inside one byte
    wr(8'h88, 8'h00); wr(8'h89, 8'h20); wr(8'h8D, r); wr(8'h8B, 8'hFF); wr(8'h88, 8'h40);
    wait_flag(1, 30); rd(8'h8B, v); chk_in(v, r, r + 8'h01);
    wr(8'h88, 8'h40); #1 chk({7'h00, ovf1}, 8'h00);
    wait_flag(1, (256 - r) * 12 + 24); chk({7'h00, ovf1}, 8'h01);
    @(posedge clk) ack1 <= 1'b1;
    @(posedge clk) ack1 <= 1'b0;
    $display("test reload done");
    wr(8'h88, 8'h00); wr(8'h89, 8'h03); wr(8'h8C, 8'hFE); wr(8'h8A, 8'h00); wr(8'h88, 8'h40);
    wait_flag(1, 40); chk({6'h00, ovf1, ovf0}, 8'h02);
    rd(8'h8A, v); chk(v, 8'h00);
    wr(8'h88, 8'h00); wr(8'h89, 8'h30); wr(8'h8B, 8'h55); wr(8'h88, 8'h40);
    repeat (40) @(posedge clk);
    rd(8'h8B, v); chk(v, 8'h55);
    $display("test split and halt done");
    wr(8'h88, 8'h00); wr(8'h89, 8'h05); wr(8'h8A, 8'h00); wr(8'h88, 8'h10);
    nz = 8'(1 + ($random(seed) & 7));
    burst(0); rd(8'h8A, v); chk(v, nz);
    wr(8'h89, 8'h09); wr(8'h8A, 8'h00);
    burst(1); rd(8'h8A, v); chk(v, nz);
    wr(8'h89, 8'h50); wr(8'h8B, 8'h00); wr(8'h88, 8'h50);
    burst(0); rd(8'h8B, v); chk(v, nz);
    $display("test external counting done");
    wr(8'h89, 8'h01); wr(8'h87, 8'h02); #1 chk({7'h00, stop}, 8'h01);
    rd(8'h8A, r);
    repeat (60) @(posedge clk);
    rd(8'h8A, v); chk(v, r);
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    #1 chk({7'h00, stop}, 8'h00);
    wr(8'h88, 8'h00); wr(8'h8A, 8'hFE); wr(8'h8C, 8'hFF); wr(8'h87, 8'h01);
    #1 chk({7'h00, hold}, 8'h01);
    wr(8'h88, 8'h10); wait_flag(0, 40);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, hold}, 8'h00);
    $display("test power control done");
    test_done;
  end
endmodule : test_dual_timer_counter_unit
